// *** core/tfr_defs.svh ***
// Register offsets, reset values, fault value and counts of the thermal fan register bank.
`ifndef TFR_DEFS_SVH
`define TFR_DEFS_SVH

// Register offsets; temperature results come high byte then low byte per channel.
`define TFR_ADDR_INT_TEMP_HI    8'h00
`define TFR_ADDR_INT_TEMP_LO    8'h01
`define TFR_ADDR_EXT1_TEMP_HI   8'h02
`define TFR_ADDR_EXT1_TEMP_LO   8'h03
`define TFR_ADDR_EXT2_TEMP_HI   8'h04
`define TFR_ADDR_EXT2_TEMP_LO   8'h05
`define TFR_ADDR_EXT3_TEMP_HI   8'h06
`define TFR_ADDR_EXT3_TEMP_LO   8'h07
`define TFR_ADDR_SHDN_TEMP      8'h0A
`define TFR_ADDR_PUSHED_ONE     8'h0C
`define TFR_ADDR_PUSHED_TWO     8'h0D
`define TFR_ADDR_THR_PIN_VOLT   8'h10
`define TFR_ADDR_EXT1_IDEAL     8'h11
`define TFR_ADDR_EXT23_IDEAL    8'h12
`define TFR_ADDR_EXT1_BETA      8'h14
`define TFR_ADDR_EXT2_BETA      8'h15
`define TFR_ADDR_REC_CFG        8'h17
`define TFR_ADDR_EXT1_CRIT      8'h19
`define TFR_ADDR_EXT2_CRIT      8'h1A
`define TFR_ADDR_EXT3_CRIT      8'h1B
`define TFR_ADDR_INT_CRIT       8'h1D
`define TFR_ADDR_CRIT_FLAGS     8'h1F
`define TFR_ADDR_SHDN_MASK      8'h20
`define TFR_ADDR_CONV_RATE      8'h21
`define TFR_ADDR_STATUS_FIRST   8'h23
`define TFR_ADDR_STATUS_LAST    8'h27
`define TFR_ADDR_CHAN_IRQ_MASK  8'h28
`define TFR_ADDR_FAN_IRQ_MASK   8'h29

// Reset values.
`define TFR_RST_ZERO            8'h00
`define TFR_RST_THR_PIN_VOLT    8'hFF
`define TFR_RST_IDEALITY        8'h12
`define TFR_RST_BETA            8'h00
`define TFR_RST_REC             8'h00
`define TFR_RST_CRIT            8'h64
`define TFR_RST_CONV_RATE       8'h0E

// Value forced into a temperature high byte on a diode fault.
`define TFR_FAULT_TEMP_HI       8'h80

// Status register count and channel count.
`define TFR_NUM_STATUS          5
`define TFR_NUM_CHAN            4

`endif

// *** core/tfr_pkg.sv ***
// Types shared by the thermal fan register bank.
`default_nettype none
package tfr_pkg;
	typedef logic [7:0] tfr_byte_t;
	// Channel order used in every per-channel vector and status bit.
	typedef enum logic [1:0] {
		TFR_CH_INT  = 2'h0,
		TFR_CH_EXT1 = 2'h1,
		TFR_CH_EXT2 = 2'h2,
		TFR_CH_EXT3 = 2'h3
	} tfr_chan_e;
endpackage
`default_nettype wire

// *** core/tfr_regs.sv ***
// Host-visible register bank of the thermal fan controller.
`include "tfr_defs.svh"
`default_nettype none
module tfr_regs #(
	parameter int EXT_CHANNELS = 3
) (
	// Clock and reset.
	input  wire logic                   sys_clk_in,
	input  wire logic                   srst_in,
	// Register port from the slave protocol engine.
	input  wire tfr_pkg::tfr_byte_t     reg_addr_in,
	input  wire logic                   reg_wr_en_in,
	input  wire tfr_pkg::tfr_byte_t     reg_wr_data_in,
	input  wire logic                   reg_rd_en_in,
	output logic                        reg_rd_valid_out,
	output tfr_pkg::tfr_byte_t          reg_rd_data_out,
	// Measurement results, the per-channel ones indexed by channel.
	input  wire logic [3:0]             temp_upd_in,
	input  wire logic [31:0]            temp_hi_in,
	input  wire logic [31:0]            temp_lo_in,
	input  wire logic [3:0]             diode_fault_in,
	input  wire logic                   thr_meas_valid_in,
	input  wire tfr_pkg::tfr_byte_t     thr_pin_volt_in,
	input  wire tfr_pkg::tfr_byte_t     shdn_temp_in,
	input  wire logic [3:0]             crit_level_in,
	// Status events, one-cycle pulses per bit.
	input  wire logic [7:0]             chan_event_in,
	input  wire logic [7:0]             upper_event_in,
	input  wire logic [7:0]             lower_event_in,
	input  wire logic [7:0]             fan_event_in,
	// Lock request from the device.
	input  wire logic                   software_lock_in,
	// Configuration, lock state and pending status to the monitor and fan logic.
	output tfr_pkg::tfr_byte_t          pushed_temp_one_out,
	output tfr_pkg::tfr_byte_t          pushed_temp_two_out,
	output tfr_pkg::tfr_byte_t          ext1_ideality_out,
	output tfr_pkg::tfr_byte_t          ext23_ideality_out,
	output tfr_pkg::tfr_byte_t          ext1_beta_out,
	output tfr_pkg::tfr_byte_t          ext2_beta_out,
	output tfr_pkg::tfr_byte_t          rec_config_out,
	output logic [31:0]                 crit_limits_out,
	output tfr_pkg::tfr_byte_t          shdn_mask_out,
	output tfr_pkg::tfr_byte_t          conv_rate_out,
	output tfr_pkg::tfr_byte_t          chan_irq_mask_out,
	output tfr_pkg::tfr_byte_t          fan_irq_mask_out,
	output logic                        software_lock_out,
	output logic                        status_pending_out
);
	import tfr_pkg::*;

	localparam logic BIG = (EXT_CHANNELS > 1);

	tfr_byte_t   temp_hi_ff [`TFR_NUM_CHAN];
	tfr_byte_t   temp_lo_ff [`TFR_NUM_CHAN];
	tfr_byte_t   status_ff  [`TFR_NUM_STATUS];
	tfr_byte_t   nxt_status [`TFR_NUM_STATUS];
	tfr_byte_t   status_set [`TFR_NUM_STATUS];
	tfr_byte_t   shdn_temp_ff;
	tfr_byte_t   thr_volt_ff;
	tfr_byte_t   crit_flags_ff;
	tfr_byte_t   crit_ff    [`TFR_NUM_CHAN];
	logic [3:0]  crit_done_ff;
	logic [3:0]  chan_present;
	logic        lock_ff;
	logic        addr_big_only;
	logic        wr_ok;
	logic        wr_lockable_ok;
	tfr_byte_t   nxt_rd_data;
	logic [2:0]  status_idx;

	// Channels EXT2 and EXT3 never take results when EXT_CHANNELS is 1.
	assign chan_present = {BIG, BIG, 1'b1, 1'b1};

	// Registers that exist only on the larger variants.
	always_comb begin
		case (reg_addr_in)
			`TFR_ADDR_EXT2_TEMP_HI, `TFR_ADDR_EXT2_TEMP_LO,
			`TFR_ADDR_EXT3_TEMP_HI, `TFR_ADDR_EXT3_TEMP_LO,
			`TFR_ADDR_EXT23_IDEAL, `TFR_ADDR_EXT2_BETA,
			`TFR_ADDR_EXT2_CRIT, `TFR_ADDR_EXT3_CRIT: addr_big_only = 1'b1;
			default: addr_big_only = 1'b0;
		endcase
	end

	// A write lands only when the variant has the register at all.
	assign wr_ok          = reg_wr_en_in && (BIG || !addr_big_only);
	assign wr_lockable_ok = wr_ok && !lock_ff;

	// The lock is sticky so that nothing but a reset can reopen the registers.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			lock_ff <= 1'b0;
		end else if (software_lock_in) begin
			lock_ff <= 1'b1;
		end
	end

	// Temperature results; a fault overrides the fresh reading of that channel.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			for (int c = 0; c < `TFR_NUM_CHAN; c++) begin
				temp_hi_ff[c] <= `TFR_RST_ZERO;
				temp_lo_ff[c] <= `TFR_RST_ZERO;
			end
		end else begin
			for (int c = 0; c < `TFR_NUM_CHAN; c++) begin
				if (chan_present[c] && diode_fault_in[c]) begin
					temp_hi_ff[c] <= `TFR_FAULT_TEMP_HI;
					temp_lo_ff[c] <= `TFR_RST_ZERO;
				end else if (chan_present[c] && temp_upd_in[c]) begin
					temp_hi_ff[c] <= temp_hi_in[c*8 +: 8];
					temp_lo_ff[c] <= temp_lo_in[c*8 +: 8];
				end
			end
		end
	end

	// Pin-derived values; the voltage holds its marker until measured once.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			thr_volt_ff   <= `TFR_RST_THR_PIN_VOLT;
			shdn_temp_ff  <= `TFR_RST_ZERO;
			crit_flags_ff <= `TFR_RST_ZERO;
		end else begin
			if (thr_meas_valid_in) begin
				thr_volt_ff  <= thr_pin_volt_in;
				shdn_temp_ff <= shdn_temp_in;
			end
			crit_flags_ff <= {4'h0, crit_level_in & chan_present};
		end
	end

	// Plain read-write configuration, some of it behind the lock.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			pushed_temp_one_out <= `TFR_RST_ZERO;
			pushed_temp_two_out <= `TFR_RST_ZERO;
			ext1_ideality_out   <= `TFR_RST_IDEALITY;
			ext23_ideality_out  <= `TFR_RST_IDEALITY;
			ext1_beta_out       <= `TFR_RST_BETA;
			ext2_beta_out       <= `TFR_RST_BETA;
			rec_config_out      <= `TFR_RST_REC;
			shdn_mask_out       <= `TFR_RST_ZERO;
			conv_rate_out       <= `TFR_RST_CONV_RATE;
			chan_irq_mask_out   <= `TFR_RST_ZERO;
			fan_irq_mask_out    <= `TFR_RST_ZERO;
		end else begin
			if (wr_ok && reg_addr_in == `TFR_ADDR_PUSHED_ONE) begin
				pushed_temp_one_out <= reg_wr_data_in;
			end
			if (wr_ok && reg_addr_in == `TFR_ADDR_PUSHED_TWO) begin
				pushed_temp_two_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_EXT1_IDEAL) begin
				ext1_ideality_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_EXT23_IDEAL) begin
				ext23_ideality_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_EXT1_BETA) begin
				ext1_beta_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_EXT2_BETA) begin
				ext2_beta_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_REC_CFG) begin
				rec_config_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_SHDN_MASK) begin
				shdn_mask_out <= reg_wr_data_in;
			end
			if (wr_lockable_ok && reg_addr_in == `TFR_ADDR_CONV_RATE) begin
				conv_rate_out <= reg_wr_data_in;
			end
			if (wr_ok && reg_addr_in == `TFR_ADDR_CHAN_IRQ_MASK) begin
				chan_irq_mask_out <= reg_wr_data_in;
			end
			if (wr_ok && reg_addr_in == `TFR_ADDR_FAN_IRQ_MASK) begin
				fan_irq_mask_out <= reg_wr_data_in;
			end
		end
	end

	// Critical limits take one write each; later writes are dropped silently.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			for (int c = 0; c < `TFR_NUM_CHAN; c++) begin
				crit_ff[c] <= `TFR_RST_CRIT;
			end
			crit_done_ff <= 4'h0;
		end else if (wr_ok) begin
			case (reg_addr_in)
				`TFR_ADDR_INT_CRIT: begin
					if (!crit_done_ff[0]) begin
						crit_ff[0]      <= reg_wr_data_in;
						crit_done_ff[0] <= 1'b1;
					end
				end
				`TFR_ADDR_EXT1_CRIT: begin
					if (!crit_done_ff[1]) begin
						crit_ff[1]      <= reg_wr_data_in;
						crit_done_ff[1] <= 1'b1;
					end
				end
				`TFR_ADDR_EXT2_CRIT: begin
					if (!crit_done_ff[2]) begin
						crit_ff[2]      <= reg_wr_data_in;
						crit_done_ff[2] <= 1'b1;
					end
				end
				`TFR_ADDR_EXT3_CRIT: begin
					if (!crit_done_ff[3]) begin
						crit_ff[3]      <= reg_wr_data_in;
						crit_done_ff[3] <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		crit_limits_out = {crit_ff[3], crit_ff[2], crit_ff[1], crit_ff[0]};
	end

	// Sticky status; an event in the very cycle of the clearing read survives.
	assign status_idx = 3'(reg_addr_in - `TFR_ADDR_STATUS_FIRST);
	always_comb begin
		status_set[0] = chan_event_in;
		status_set[1] = upper_event_in;
		status_set[2] = lower_event_in;
		status_set[3] = {4'h0, diode_fault_in & chan_present};
		status_set[4] = fan_event_in;
		for (int s = 0; s < `TFR_NUM_STATUS; s++) begin
			nxt_status[s] = status_ff[s];
			if (reg_rd_en_in && reg_addr_in >= `TFR_ADDR_STATUS_FIRST &&
				reg_addr_in <= `TFR_ADDR_STATUS_LAST && int'(status_idx) == s) begin
				nxt_status[s] = `TFR_RST_ZERO;
			end
			nxt_status[s] = nxt_status[s] | status_set[s];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			for (int s = 0; s < `TFR_NUM_STATUS; s++) begin
				status_ff[s] <= `TFR_RST_ZERO;
			end
		end else begin
			for (int s = 0; s < `TFR_NUM_STATUS; s++) begin
				status_ff[s] <= nxt_status[s];
			end
		end
	end

	// Read mux; anything unmapped or absent on this variant reads zero.
	always_comb begin
		nxt_rd_data = `TFR_RST_ZERO;
		case (reg_addr_in)
			`TFR_ADDR_INT_TEMP_HI:   nxt_rd_data = temp_hi_ff[0];
			`TFR_ADDR_INT_TEMP_LO:   nxt_rd_data = temp_lo_ff[0];
			`TFR_ADDR_EXT1_TEMP_HI:  nxt_rd_data = temp_hi_ff[1];
			`TFR_ADDR_EXT1_TEMP_LO:  nxt_rd_data = temp_lo_ff[1];
			`TFR_ADDR_EXT2_TEMP_HI:  nxt_rd_data = temp_hi_ff[2];
			`TFR_ADDR_EXT2_TEMP_LO:  nxt_rd_data = temp_lo_ff[2];
			`TFR_ADDR_EXT3_TEMP_HI:  nxt_rd_data = temp_hi_ff[3];
			`TFR_ADDR_EXT3_TEMP_LO:  nxt_rd_data = temp_lo_ff[3];
			`TFR_ADDR_SHDN_TEMP:     nxt_rd_data = shdn_temp_ff;
			`TFR_ADDR_PUSHED_ONE:    nxt_rd_data = pushed_temp_one_out;
			`TFR_ADDR_PUSHED_TWO:    nxt_rd_data = pushed_temp_two_out;
			`TFR_ADDR_THR_PIN_VOLT:  nxt_rd_data = thr_volt_ff;
			`TFR_ADDR_EXT1_IDEAL:    nxt_rd_data = ext1_ideality_out;
			`TFR_ADDR_EXT23_IDEAL:   nxt_rd_data = ext23_ideality_out;
			`TFR_ADDR_EXT1_BETA:     nxt_rd_data = ext1_beta_out;
			`TFR_ADDR_EXT2_BETA:     nxt_rd_data = ext2_beta_out;
			`TFR_ADDR_REC_CFG:       nxt_rd_data = rec_config_out;
			`TFR_ADDR_INT_CRIT:      nxt_rd_data = crit_ff[0];
			`TFR_ADDR_EXT1_CRIT:     nxt_rd_data = crit_ff[1];
			`TFR_ADDR_EXT2_CRIT:     nxt_rd_data = crit_ff[2];
			`TFR_ADDR_EXT3_CRIT:     nxt_rd_data = crit_ff[3];
			`TFR_ADDR_CRIT_FLAGS:    nxt_rd_data = crit_flags_ff;
			`TFR_ADDR_SHDN_MASK:     nxt_rd_data = shdn_mask_out;
			`TFR_ADDR_CONV_RATE:     nxt_rd_data = conv_rate_out;
			`TFR_ADDR_CHAN_IRQ_MASK: nxt_rd_data = chan_irq_mask_out;
			`TFR_ADDR_FAN_IRQ_MASK:  nxt_rd_data = fan_irq_mask_out;
			default: begin
				if (reg_addr_in >= `TFR_ADDR_STATUS_FIRST &&
					reg_addr_in <= `TFR_ADDR_STATUS_LAST) begin
					nxt_rd_data = status_ff[status_idx];
				end
			end
		endcase
		if (addr_big_only && !BIG) begin
			nxt_rd_data = `TFR_RST_ZERO;
		end
	end

	// Read answer is registered, one cycle after the strobe.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			reg_rd_valid_out  <= 1'b0;
			reg_rd_data_out   <= `TFR_RST_ZERO;
			software_lock_out <= 1'b0;
			status_pending_out <= 1'b0;
		end else begin
			reg_rd_valid_out  <= reg_rd_en_in;
			reg_rd_data_out   <= reg_rd_en_in ? nxt_rd_data : `TFR_RST_ZERO;
			software_lock_out <= lock_ff;
			status_pending_out <= |{status_ff[0] & chan_irq_mask_out,
				status_ff[4] & fan_irq_mask_out};
		end
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);

	rd_latency_a: assert property (reg_rd_en_in |=> reg_rd_valid_out)
		else $error("read answer missing");
	small_zero_a: assert property ((!BIG && reg_rd_en_in && addr_big_only)
		|=> reg_rd_data_out == `TFR_RST_ZERO)
		else $error("small variant read not zero");
	ro_temp_a: assert property ((wr_ok && reg_addr_in == `TFR_ADDR_INT_TEMP_HI &&
		!temp_upd_in[0] && !diode_fault_in[0]) |=> $stable(temp_hi_ff[0]))
		else $error("read-only temperature changed");
	thr_marker_a: assert property ((thr_volt_ff == `TFR_RST_THR_PIN_VOLT &&
		!thr_meas_valid_in) |=> thr_volt_ff == `TFR_RST_THR_PIN_VOLT)
		else $error("threshold voltage left marker");
	once_only_a: assert property ((crit_done_ff[1] && reg_wr_en_in &&
		reg_addr_in == `TFR_ADDR_EXT1_CRIT) |=> $stable(crit_ff[1]))
		else $error("critical limit rewritten");
	conv_write_a: assert property ((wr_ok && !lock_ff &&
		reg_addr_in == `TFR_ADDR_CONV_RATE) |=> conv_rate_out == $past(reg_wr_data_in))
		else $error("conversion rate not written");
	clear_read_a: assert property ((reg_rd_en_in && reg_addr_in == 8'h24 &&
		upper_event_in == `TFR_RST_ZERO) |=> status_ff[1] == `TFR_RST_ZERO)
		else $error("status not cleared on read");
	set_wins_a: assert property ((reg_rd_en_in && reg_addr_in == `TFR_ADDR_STATUS_LAST &&
		fan_event_in[0]) |=> status_ff[4][0])
		else $error("event lost to clearing read");
	fault_force_a: assert property (diode_fault_in[1]
		|=> temp_hi_ff[1] == `TFR_FAULT_TEMP_HI && status_ff[3][1])
		else $error("fault did not force temperature");
	lock_hold_a: assert property ((lock_ff && reg_wr_en_in &&
		reg_addr_in == `TFR_ADDR_EXT1_IDEAL) |=> $stable(ext1_ideality_out))
		else $error("locked register written");
	irq_gate_a: assert property (((status_ff[0] & chan_irq_mask_out) !=
		`TFR_RST_ZERO) |=> status_pending_out)
		else $error("enabled event not pending");
endmodule
`default_nettype wire

// *** sim/tfr_host_model.sv ***
// Host-side model that issues single-byte register reads and writes to the bank.
`default_nettype none
module tfr_host_model (
	// Clock.
	input  wire logic               sys_clk_in,
	// Request lines towards the register bank.
	output tfr_pkg::tfr_byte_t      reg_addr_out,
	output logic                    reg_wr_en_out,
	output tfr_pkg::tfr_byte_t      reg_wr_data_out,
	output logic                    reg_rd_en_out,
	// Answer lines from the register bank.
	input  wire logic               reg_rd_valid_in,
	input  wire tfr_pkg::tfr_byte_t reg_rd_data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	import tfr_pkg::*;

	// Idle lines start at a known value so nothing floats into the bank.
	initial begin
		reg_addr_out    = 8'h00;
		reg_wr_en_out   = 1'b0;
		reg_wr_data_out = 8'h00;
		reg_rd_en_out   = 1'b0;
	end

	// One write strobe per byte; released lines show the inverse, not the old value.
	task automatic wr(input tfr_byte_t a, input tfr_byte_t d);
		@(negedge sys_clk_in);
		reg_addr_out    = a;
		reg_wr_data_out = d;
		reg_wr_en_out   = 1'b1;
		@(negedge sys_clk_in);
		reg_wr_en_out   = 1'b0;
		reg_addr_out    = ~a;
		reg_wr_data_out = ~d;
	endtask

	// The answer stands exactly one cycle after the strobe edge, so it is sampled then.
	task automatic rd(input tfr_byte_t a, output tfr_byte_t d, output logic ok);
		@(negedge sys_clk_in);
		reg_addr_out  = a;
		reg_rd_en_out = 1'b1;
		@(negedge sys_clk_in);
		reg_rd_en_out = 1'b0;
		reg_addr_out  = ~a;
		ok            = reg_rd_valid_in;
		d             = reg_rd_data_in;
	endtask
endmodule
`default_nettype wire

// *** sim/tfr_tb.sv ***
// Self-checking testbench of the thermal fan register bank.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import tfr_pkg::*;

	typedef struct packed {
		logic      wr;
		tfr_byte_t addr;
		tfr_byte_t data;
	} tfr_row_s;

	logic        sys_clk_in, srst_in, rd_valid, thr_meas_valid_in, software_lock_in;
	logic        wr_en, rd_en, software_lock_out, status_pending_out, rd_valid_s;
	tfr_byte_t   addr, wr_data, rd_data, thr_pin_volt_in, shdn_temp_in;
	tfr_byte_t   pushed_one, conv_rate, rd_data_s;
	logic [3:0]  temp_upd_in, diode_fault_in, crit_level_in;
	logic [31:0] temp_hi_in, temp_lo_in, crit_limits;
	logic [7:0]  chan_ev, upper_ev, lower_ev, fan_ev;
	int          failures, checks_done;
	tfr_byte_t   ev_addr [4] = '{8'h23, 8'h24, 8'h25, 8'h27};
	tfr_byte_t   ev_val  [4] = '{8'h11, 8'h22, 8'h44, 8'h88};
	tfr_row_s    rows [40] = '{
		'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h07, 8'h00},
		'{1'b0, 8'h10, 8'hFF}, '{1'b0, 8'h0A, 8'h00},
		'{1'b0, 8'h11, 8'h12}, '{1'b0, 8'h12, 8'h12},
		'{1'b0, 8'h19, 8'h64}, '{1'b0, 8'h1D, 8'h64},
		'{1'b0, 8'h21, 8'h0E}, '{1'b0, 8'h20, 8'h00},
		'{1'b0, 8'h29, 8'h00}, '{1'b1, 8'h0C, 8'hA5},
		'{1'b0, 8'h0C, 8'hA5}, '{1'b1, 8'h00, 8'h55},
		'{1'b0, 8'h00, 8'h00}, '{1'b1, 8'h08, 8'h3C},
		'{1'b0, 8'h08, 8'h00}, '{1'b1, 8'h19, 8'h3C},
		'{1'b1, 8'h19, 8'h77}, '{1'b0, 8'h19, 8'h3C},
		'{1'b1, 8'h21, 8'h05}, '{1'b0, 8'h21, 8'h05},
		'{1'b1, 8'h28, 8'h01}, '{1'b0, 8'h28, 8'h01},
		'{1'b1, 8'h17, 8'hC3}, '{1'b0, 8'h17, 8'hC3},
		'{1'b1, 8'h14, 8'h5A}, '{1'b0, 8'h14, 8'h5A},
		'{1'b1, 8'h20, 8'h81}, '{1'b0, 8'h20, 8'h81},
		'{1'b1, 8'h1F, 8'h77}, '{1'b0, 8'h1F, 8'h00},
		'{1'b1, 8'h29, 8'h80}, '{1'b0, 8'h29, 8'h80},
		'{1'b1, 8'h0D, 8'h3C}, '{1'b0, 8'h0D, 8'h3C},
		'{1'b1, 8'h12, 8'h34}, '{1'b0, 8'h12, 8'h34},
		'{1'b1, 8'h15, 8'hA6}, '{1'b0, 8'h15, 8'hA6}
	};

	tfr_regs #(.EXT_CHANNELS(3)) tfr_regs_i (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(addr),
		.reg_wr_en_in(wr_en), .reg_wr_data_in(wr_data), .reg_rd_en_in(rd_en),
		.reg_rd_valid_out(rd_valid), .reg_rd_data_out(rd_data),
		.temp_upd_in(temp_upd_in), .temp_hi_in(temp_hi_in), .temp_lo_in(temp_lo_in),
		.diode_fault_in(diode_fault_in), .thr_meas_valid_in(thr_meas_valid_in),
		.thr_pin_volt_in(thr_pin_volt_in), .shdn_temp_in(shdn_temp_in),
		.crit_level_in(crit_level_in), .chan_event_in(chan_ev), .upper_event_in(upper_ev),
		.lower_event_in(lower_ev), .fan_event_in(fan_ev),
		.software_lock_in(software_lock_in), .pushed_temp_one_out(pushed_one),
		.pushed_temp_two_out(), .ext1_ideality_out(), .ext23_ideality_out(),
		.ext1_beta_out(), .ext2_beta_out(), .rec_config_out(),
		.crit_limits_out(crit_limits), .shdn_mask_out(), .conv_rate_out(conv_rate),
		.chan_irq_mask_out(), .fan_irq_mask_out(),
		.software_lock_out(software_lock_out), .status_pending_out(status_pending_out)
	);

	// Small variant on the same inputs; only its read answer is watched.
	tfr_regs #(.EXT_CHANNELS(1)) tfr_regs_small_i (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(addr),
		.reg_wr_en_in(wr_en), .reg_wr_data_in(wr_data), .reg_rd_en_in(rd_en),
		.reg_rd_valid_out(rd_valid_s), .reg_rd_data_out(rd_data_s),
		.temp_upd_in(temp_upd_in), .temp_hi_in(temp_hi_in), .temp_lo_in(temp_lo_in),
		.diode_fault_in(diode_fault_in), .thr_meas_valid_in(thr_meas_valid_in),
		.thr_pin_volt_in(thr_pin_volt_in), .shdn_temp_in(shdn_temp_in),
		.crit_level_in(crit_level_in), .chan_event_in(chan_ev), .upper_event_in(upper_ev),
		.lower_event_in(lower_ev), .fan_event_in(fan_ev),
		.software_lock_in(software_lock_in), .pushed_temp_one_out(),
		.pushed_temp_two_out(), .ext1_ideality_out(), .ext23_ideality_out(),
		.ext1_beta_out(), .ext2_beta_out(), .rec_config_out(),
		.crit_limits_out(), .shdn_mask_out(), .conv_rate_out(),
		.chan_irq_mask_out(), .fan_irq_mask_out(),
		.software_lock_out(), .status_pending_out()
	);

	tfr_host_model tfr_host_model_i (
		.sys_clk_in(sys_clk_in), .reg_addr_out(addr), .reg_wr_en_out(wr_en),
		.reg_wr_data_out(wr_data), .reg_rd_en_out(rd_en),
		.reg_rd_valid_in(rd_valid), .reg_rd_data_in(rd_data)
	);

	// Free-running system clock, 50 ns period.
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Compares a seen value with the expected one and counts both outcomes.
	task automatic chk(input string name, input tfr_byte_t seen, input tfr_byte_t exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// A read whose answer never shows is fatal to the run, so it goes straight to the report.
	task automatic rdc(input tfr_byte_t a, input tfr_byte_t e);
		tfr_byte_t d;
		logic      ok;
		tfr_host_model_i.rd(a, d, ok);
		chk("rd_valid", {7'h00, ok}, 8'h01);
		if (ok !== 1'b1)
			print_verdict();
		else
			chk("rd_data", d, e);
	endtask

	// Waits for n falling edges, where all inputs change.
	task automatic fall(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	initial begin
		failures = 0;
		checks_done = 0;
		srst_in = 1'b1;
		{temp_upd_in, diode_fault_in, crit_level_in, temp_hi_in, temp_lo_in} = '0;
		{thr_meas_valid_in, thr_pin_volt_in, shdn_temp_in, software_lock_in} = '0;
		{chan_ev, upper_ev, lower_ev, fan_ev} = '0;
		fall(3);
		srst_in = 1'b0;
		// Table of plain accesses: reset-value reads, then writes and read-backs.
		foreach (rows[i]) begin
			if (rows[i].wr)
				tfr_host_model_i.wr(rows[i].addr, rows[i].data);
			else
				rdc(rows[i].addr, rows[i].data);
		end
		chk("pushed_one", pushed_one, 8'hA5);
		chk("conv_rate", conv_rate, 8'h05);
		chk("crit_ext1", crit_limits[15:8], 8'h3C);
		// The small variant ignored the big-only write and reads it as zero.
		rdc(8'h12, 8'h34);
		chk("small_valid", {7'h00, rd_valid_s}, 8'h01);
		chk("small_rd", rd_data_s, 8'h00);
		// New result on external channel one lands in its byte pair.
		fall(1);
		temp_hi_in[15:8] = 8'h2B;
		temp_lo_in[15:8] = 8'hE0;
		temp_upd_in = 4'h2;
		fall(1);
		temp_upd_in = 4'h0;
		rdc(8'h02, 8'h2B);
		rdc(8'h03, 8'hE0);
		// Faults on external channels one and two, flags cleared by the first read.
		diode_fault_in = 4'h6;
		fall(1);
		diode_fault_in = 4'h0;
		rdc(8'h04, 8'h80);
		chk("small_rd", rd_data_s, 8'h00);
		rdc(8'h02, 8'h80);
		chk("small_rd", rd_data_s, 8'h80);
		rdc(8'h26, 8'h06);
		rdc(8'h26, 8'h00);
		// All event flags at once; each register clears on its own read.
		{chan_ev, upper_ev, lower_ev, fan_ev} = {8'h11, 8'h22, 8'h44, 8'h88};
		fall(1);
		{chan_ev, upper_ev, lower_ev, fan_ev} = '0;
		fall(1);
		chk("pending", {7'h00, status_pending_out}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			rdc(ev_addr[i], ev_val[i]);
			rdc(ev_addr[i], 8'h00);
			chk("pending", {7'h00, status_pending_out}, (i < 3) ? 8'h01 : 8'h00);
		end
		chk("pending", {7'h00, status_pending_out}, 8'h00);
		// A fan event in the cycle of the clearing read survives it.
		fork
			rdc(8'h27, 8'h00);
			begin
				fall(1);
				fan_ev = 8'h01;
				fall(1);
				fan_ev = 8'h00;
			end
		join
		rdc(8'h27, 8'h01);
		rdc(8'h27, 8'h00);
		// Threshold pin measurement and critical comparisons.
		{thr_pin_volt_in, shdn_temp_in, thr_meas_valid_in} = {8'h7C, 8'h5A, 1'b1};
		crit_level_in = 4'hA;
		fall(1);
		thr_meas_valid_in = 1'b0;
		rdc(8'h10, 8'h7C);
		rdc(8'h0A, 8'h5A);
		rdc(8'h1F, 8'h0A);
		// Lock freezes lockable registers but not pushed temperatures.
		software_lock_in = 1'b1;
		fall(1);
		software_lock_in = 1'b0;
		fall(2);
		chk("lock", {7'h00, software_lock_out}, 8'h01);
		tfr_host_model_i.wr(8'h21, 8'h09);
		tfr_host_model_i.wr(8'h0C, 8'h3E);
		rdc(8'h21, 8'h05);
		rdc(8'h0C, 8'h3E);
		tfr_host_model_i.wr(8'h11, 8'h40);
		rdc(8'h11, 8'h12);
		// Second reset in mid-run restores defaults and releases the lock.
		srst_in = 1'b1;
		fall(3);
		srst_in = 1'b0;
		chk("lock", {7'h00, software_lock_out}, 8'h00);
		rdc(8'h21, 8'h0E);
		rdc(8'h19, 8'h64);
		rdc(8'h02, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
